// ---- bench/counter_model.sv ----
// counter model that feeds count and tick to the compare unit
`timescale 1ns/1ps

module counter_model
	import ocm_pkg::*;
(
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic run_in,
	input wire logic load_in,
	input wire logic [ocm_pkg::CNT_W-1:0] load_val_in,
	output logic tick_out,
	output logic [ocm_pkg::CNT_W-1:0] count_out
);
	logic [1:0] div_r;
	logic [CNT_W-1:0] count_r;

	// one tick every fourth clock, counting up only, so no floor or ceiling writes
	assign tick_out = run_in && (div_r == 2'h3);
	assign count_out = count_r;

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			div_r <= 2'h0;
			count_r <= 16'h0000;
		end else begin
			div_r <= run_in ? div_r + 2'h1 : 2'h0;
			if (load_in) begin
				count_r <= load_val_in;
			end else if (tick_out) begin
				count_r <= count_r + 16'h0001;
			end
		end
	end
endmodule

// ---- bench/test_output_compare_match_unit.sv ----
// self-checking bench for the output compare match unit
`timescale 1ns/1ps

`define CHK(nm, exp, got) \
	n_tests++; \
	if ((got) !== (exp)) begin \
		err_total++; \
		$display("Error %s expected %h seen %h", nm, exp, got); \
	end

module test_output_compare_match_unit;
	import ocm_pkg::*;
	logic clk, rst_n, psel, penable, pwrite, port, run, tick, perr, st;
	logic [ADDR_W-1:0] paddr;
	logic [DATA_W-1:0] pwdata, prdata, rdat;
	logic [CNT_W-1:0] count, cwdata;
	logic pready, pslverr, cwr, match, flag, pin;
	logic [1:0] coms [4] = '{2'h1, 2'h2, 2'h3, 2'h1};
	int err_total = 0;
	int n_tests = 0;

	output_compare_match_unit dut (.CLOCK_IN(clk), .RST_N_IN(rst_n), .PSEL_IN(psel),
		.PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
		.PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .TICK_IN(tick),
		.COUNT_IN(count), .CEILING_IN(1'b0), .FLOOR_IN(1'b0), .COUNT_DOWN_IN(1'b0),
		.PORT_IN(port), .COUNT_WR_OUT(cwr), .COUNT_WDATA_OUT(cwdata), .MATCH_OUT(match),
		.FLAG_OUT(flag), .PIN_OUT(pin));

	counter_model partner (.clk_in(clk), .rst_n_in(rst_n), .run_in(run), .load_in(cwr),
		.load_val_in(cwdata), .tick_out(tick), .count_out(count));

	// ********
	// bus tasks
	// ********
	task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rdat = prdata;
		perr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rd(input logic [ADDR_W-1:0] a);
		apb(1'b0, a, 32'h00000000);
	endtask

	function automatic logic nxt(input logic [1:0] c, input logic s);
		return (c == COM_TOGGLE) ? ~s : (c == COM_CLEAR) ? 1'b0 : (c == COM_SET) ? 1'b1 : s;
	endfunction

	// load the counter, let it run in toggle mode and look for one match
	task automatic run_to(input logic [15:0] start, input logic [15:0] cmp, input logic hit);
		logic seen;
		seen = 1'b0;
		wr(COUNTER_OFS, {16'h0000, start});
		run <= 1'b1;
		repeat (40) begin
			// sample off the launching edge so match and count are settled
			@(negedge clk);
			if (match === 1'b1 && !seen) begin
				seen = 1'b1;
				`CHK("count at match", cmp + 16'h0001, count)
			end
		end
		@(posedge clk);
		run <= 1'b0;
		if (hit) st = ~st;
		`CHK("match seen", hit, seen)
		rd(STATUS_OFS);
		`CHK("status", {st, hit}, rdat[1:0])
		wr(STATUS_OFS, 32'h00000001);
	endtask

	task final_report;
		$display("Comparisons %0d, mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// ********
	// clock and watchdog
	// ********
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	initial begin
		repeat (20000) @(posedge clk);
		err_total++;
		final_report;
	end

	// ********
	// scenarios
	// ********
	initial begin
		{rst_n, psel, penable, pwrite, run} = '0;
		paddr = '0;
		pwdata = '0;
		port = 1'b1;
		st = 1'b0;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		@(negedge clk);
		`CHK("pin after reset", 1'b1, pin)
		rd(STATUS_OFS);
		`CHK("state after reset", 2'h0, rdat[1:0])
		rd(8'hFC);
		`CHK("unmapped error", 1'b1, perr)
		`CHK("unmapped data", 32'h00000000, rdat)
		for (int i = 0; i < 4; i++) begin
			wr(CTRL_OFS, 32'(coms[i]) << CTRL_COM_LSB);
			wr(FORCE_OFS, 32'h00000001);
			st = nxt(coms[i], st);
			rd(STATUS_OFS);
			`CHK("forced state", {st, 1'b0}, rdat[1:0])
			@(negedge clk);
			`CHK("pin source", st, pin)
		end
		`CHK("counter untouched", 16'h0000, count)
		wr(CTRL_OFS, 32'h00000035);
		wr(FORCE_OFS, 32'h00000001);
		wr(CTRL_OFS, 32'h00000010);
		rd(STATUS_OFS);
		`CHK("state kept", {st, 1'b0}, rdat[1:0])
		wr(CMP_HIGH_OFS, 32'h00000000);
		wr(CMP_LOW_OFS, 32'h00000005);
		run_to(16'h0003, 16'h0005, 1'b1);
		wr(CMP_HIGH_OFS, 32'h00000001);
		run_to(16'h0003, 16'h0005, 1'b1);
		wr(CMP_LOW_OFS, 32'h00000005);
		run_to(16'h0103, 16'h0105, 1'b1);
		run_to(16'h0105, 16'h0105, 1'b0);
		wr(CTRL_OFS, 32'h00000000);
		@(negedge clk);
		`CHK("pin to port", 1'b1, pin)
		@(posedge clk);
		port <= 1'b0;
		@(negedge clk);
		`CHK("pin follows port", 1'b0, pin)
		final_report;
	end
endmodule

// ---- hw/compare_value_store.sv ----
// staged 16-bit compare value with optional double buffering
`timescale 1ns/1ps

module compare_value_store #(
	parameter int WIDTH = ocm_pkg::CNT_W,
	parameter int BYTE = ocm_pkg::BYTE_W
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic high_wr,
	input wire logic low_wr,
	input wire logic [BYTE-1:0] wdata,
	input wire logic buffered,
	input wire logic update,
	output logic [WIDTH-1:0] buffer_val,
	output logic [WIDTH-1:0] active_val
);
	import ocm_pkg::*;

	logic [BYTE-1:0] staged_r;
	logic [WIDTH-1:0] buffer_r;
	logic [WIDTH-1:0] active_r;
	logic [WIDTH-1:0] word_nxt;

	assign word_nxt = {staged_r, wdata};
	assign buffer_val = buffer_r;
	assign active_val = active_r;

	// ************************************************************
	// shared high-byte stage, buffer and active value
	// ************************************************************
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			staged_r <= BYTE_RST;
			buffer_r <= CMP_RST;
			active_r <= CMP_RST;
		end else begin
			if (high_wr) begin
				staged_r <= wdata;
			end
			if (low_wr) begin
				buffer_r <= word_nxt;
			end
			if (low_wr && !buffered) begin
				active_r <= word_nxt;
			end else if (buffered && update) begin
				active_r <= buffer_r;
			end
		end
	end

	a_low_completes_word: assert property (@(posedge clk) disable iff (!rst_n)
		low_wr && !buffered |=> active_r == {$past(staged_r), $past(wdata)})
		else $error("low byte write did not complete the word");
	a_high_not_active: assert property (@(posedge clk) disable iff (!rst_n)
		high_wr && !low_wr && !update |=> $stable(active_r))
		else $error("high byte write reached the active value");

endmodule

// ---- hw/ocm_pkg.sv ----
// constants for the output compare match unit
package ocm_pkg;

	// ************************************************************
	// widths
	// ************************************************************
	localparam int DATA_W = 32;
	localparam int ADDR_W = 8;
	localparam int CNT_W = 16;
	localparam int BYTE_W = 8;
	localparam int MODE_W = 4;
	localparam int COM_W = 2;

	// ************************************************************
	// register byte offsets
	// ************************************************************
	localparam logic [ADDR_W-1:0] CTRL_OFS = 8'h00;
	localparam logic [ADDR_W-1:0] FORCE_OFS = 8'h04;
	localparam logic [ADDR_W-1:0] COUNTER_OFS = 8'h08;
	localparam logic [ADDR_W-1:0] CMP_LOW_OFS = 8'h0C;
	localparam logic [ADDR_W-1:0] CMP_HIGH_OFS = 8'h10;
	localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h14;

	// ************************************************************
	// field positions
	// ************************************************************
	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_COM_LSB = 4;
	localparam int FORCE_BIT = 0;
	localparam int STAT_FLAG_BIT = 0;
	localparam int STAT_STATE_BIT = 1;

	// ************************************************************
	// reset values and mode codes
	// ************************************************************
	localparam logic [MODE_W-1:0] MODE_RST = 4'h0;
	localparam logic [COM_W-1:0] COM_RST = 2'h0;
	localparam logic [BYTE_W-1:0] BYTE_RST = 8'h00;
	localparam logic [CNT_W-1:0] CMP_RST = 16'h0000;
	localparam logic [MODE_W-1:0] MODE_NORMAL = 4'h0;
	localparam logic [MODE_W-1:0] MODE_CTC_A = 4'h4;
	localparam logic [MODE_W-1:0] MODE_CTC_ICR = 4'hC;
	localparam logic [MODE_W-1:0] MODE_PFC_ICR = 4'h8;
	localparam logic [MODE_W-1:0] MODE_PFC_A = 4'h9;
	localparam logic [MODE_W-1:0] MODE_FAST_LO = 4'h5;
	localparam logic [MODE_W-1:0] MODE_FAST_HI = 4'h7;
	localparam logic [MODE_W-1:0] MODE_FAST_ICR = 4'hE;
	localparam logic [MODE_W-1:0] MODE_FAST_A = 4'hF;

	typedef enum logic [COM_W-1:0] {
		COM_OFF,
		COM_TOGGLE,
		COM_CLEAR,
		COM_SET
	} com_t;

endpackage

// ---- hw/output_compare_match_unit.sv ----
// output compare match unit with apb register access
`timescale 1ns/1ps

module output_compare_match_unit (
	input wire logic CLOCK_IN,
	input wire logic RST_N_IN,
	input wire logic PSEL_IN,
	input wire logic PENABLE_IN,
	input wire logic PWRITE_IN,
	input wire logic [ocm_pkg::ADDR_W-1:0] PADDR_IN,
	input wire logic [ocm_pkg::DATA_W-1:0] PWDATA_IN,
	output logic [ocm_pkg::DATA_W-1:0] PRDATA_OUT,
	output logic PREADY_OUT,
	output logic PSLVERR_OUT,
	input wire logic TICK_IN,
	input wire logic [ocm_pkg::CNT_W-1:0] COUNT_IN,
	input wire logic CEILING_IN,
	input wire logic FLOOR_IN,
	input wire logic COUNT_DOWN_IN,
	input wire logic PORT_IN,
	output logic COUNT_WR_OUT,
	output logic [ocm_pkg::CNT_W-1:0] COUNT_WDATA_OUT,
	output logic MATCH_OUT,
	output logic FLAG_OUT,
	output logic PIN_OUT
);
	import ocm_pkg::*;

	// ************************************************************
	// bus decode
	// ************************************************************
	wire wr_en = PSEL_IN && PENABLE_IN && PWRITE_IN;
	wire rd_en = PSEL_IN && PENABLE_IN && !PWRITE_IN;
	wire hit_ctrl = PADDR_IN == CTRL_OFS;
	wire hit_force = PADDR_IN == FORCE_OFS;
	wire hit_count = PADDR_IN == COUNTER_OFS;
	wire hit_low = PADDR_IN == CMP_LOW_OFS;
	wire hit_high = PADDR_IN == CMP_HIGH_OFS;
	wire hit_stat = PADDR_IN == STATUS_OFS;
	wire hit_any = hit_ctrl || hit_force || hit_count || hit_low || hit_high || hit_stat;
	wire wr_ctrl = wr_en && hit_ctrl;
	wire wr_force = wr_en && hit_force && PWDATA_IN[FORCE_BIT];
	wire wr_count = wr_en && hit_count;
	wire wr_low = wr_en && hit_low;
	wire wr_high = wr_en && hit_high;
	wire clr_flag = wr_en && hit_stat && PWDATA_IN[STAT_FLAG_BIT];

	// ************************************************************
	// state
	// ************************************************************
	logic [MODE_W-1:0] mode_r;
	logic [MODE_W-1:0] mode_nxt;
	logic [COM_W-1:0] com_r;
	logic [COM_W-1:0] com_nxt;
	logic state_r;
	logic state_nxt;
	logic flag_r;
	logic flag_nxt;
	logic block_r;
	logic block_nxt;
	logic match_r;
	logic count_wr_r;
	logic [CNT_W-1:0] count_wdata_r;
	logic [DATA_W-1:0] rdata_r;
	logic [DATA_W-1:0] rdata_nxt;
	logic [CNT_W-1:0] buffer_val;
	logic [CNT_W-1:0] active_val;

	// ************************************************************
	// mode classes
	// ************************************************************
	wire non_pwm = mode_r == MODE_NORMAL || mode_r == MODE_CTC_A || mode_r == MODE_CTC_ICR;
	wire fast_pwm = (mode_r >= MODE_FAST_LO && mode_r <= MODE_FAST_HI) ||
		mode_r == MODE_FAST_ICR || mode_r == MODE_FAST_A;
	wire floor_update = mode_r == MODE_PFC_ICR || mode_r == MODE_PFC_A;
	wire dual_pwm = !non_pwm && !fast_pwm;
	wire buf_update = floor_update ? FLOOR_IN : CEILING_IN;
	wire com_off = com_r == COM_OFF;

	// ************************************************************
	// compare value store
	// ************************************************************
	compare_value_store #(
		.WIDTH(CNT_W),
		.BYTE(BYTE_W)
	) u_store (
		.clk(CLOCK_IN),
		.rst_n(RST_N_IN),
		.high_wr(wr_high),
		.low_wr(wr_low),
		.wdata(PWDATA_IN[BYTE_W-1:0]),
		.buffered(!non_pwm),
		.update(buf_update),
		.buffer_val(buffer_val),
		.active_val(active_val)
	);

	// ************************************************************
	// match detection
	// ************************************************************
	wire equal = COUNT_IN == active_val;
	wire real_match = TICK_IN && equal && !block_r;
	wire forced = wr_force && non_pwm;

	// output action for a match or a forced match
	logic act_set;
	logic act_clr;
	logic act_tgl;
	always_comb begin
		act_set = 1'b0;
		act_clr = 1'b0;
		act_tgl = 1'b0;
		case (com_t'(com_r))
			COM_TOGGLE: act_tgl = non_pwm;
			COM_CLEAR: act_clr = !(dual_pwm && COUNT_DOWN_IN);
			COM_SET: act_set = !(dual_pwm && COUNT_DOWN_IN);
			COM_OFF: act_tgl = 1'b0;
			default: act_tgl = 1'b0;
		endcase
		if (dual_pwm && COUNT_DOWN_IN) begin
			act_set = com_r == COM_CLEAR;
			act_clr = com_r == COM_SET;
		end
	end

	// ceiling action in fast pwm restores the level opposite to the match action
	wire ceil_act = fast_pwm && CEILING_IN && TICK_IN && !real_match;

	always_comb begin
		state_nxt = state_r;
		if (real_match || forced) begin
			if (act_set) begin
				state_nxt = 1'b1;
			end else if (act_clr) begin
				state_nxt = 1'b0;
			end else if (act_tgl) begin
				state_nxt = !state_r;
			end
		end else if (ceil_act) begin
			if (com_r == COM_CLEAR) begin
				state_nxt = 1'b1;
			end else if (com_r == COM_SET) begin
				state_nxt = 1'b0;
			end
		end
	end

	// set wins over the clear; a forced match never sets the flag
	assign flag_nxt = real_match ? 1'b1 : (clr_flag ? 1'b0 : flag_r);
	// a counter write arms the block until the next timer tick
	assign block_nxt = wr_count ? 1'b1 : (TICK_IN ? 1'b0 : block_r);
	assign mode_nxt = wr_ctrl ? PWDATA_IN[CTRL_MODE_LSB +: MODE_W] : mode_r;
	assign com_nxt = wr_ctrl ? PWDATA_IN[CTRL_COM_LSB +: COM_W] : com_r;

	// ************************************************************
	// read data
	// ************************************************************
	wire [CNT_W-1:0] cpu_view = non_pwm ? active_val : buffer_val;
	always_comb begin
		rdata_nxt = '0;
		if (hit_ctrl) begin
			rdata_nxt[CTRL_MODE_LSB +: MODE_W] = mode_r;
			rdata_nxt[CTRL_COM_LSB +: COM_W] = com_r;
		end else if (hit_count) begin
			rdata_nxt[CNT_W-1:0] = COUNT_IN;
		end else if (hit_low) begin
			rdata_nxt[BYTE_W-1:0] = cpu_view[BYTE_W-1:0];
		end else if (hit_high) begin
			rdata_nxt[BYTE_W-1:0] = cpu_view[CNT_W-1:BYTE_W];
		end else if (hit_stat) begin
			rdata_nxt[STAT_FLAG_BIT] = flag_r;
			rdata_nxt[STAT_STATE_BIT] = state_r;
		end
	end

	// ************************************************************
	// registers
	// ************************************************************
	always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			mode_r <= MODE_RST;
			com_r <= COM_RST;
			state_r <= 1'b0;
			flag_r <= 1'b0;
			block_r <= 1'b0;
			match_r <= 1'b0;
			count_wr_r <= 1'b0;
			count_wdata_r <= CMP_RST;
			rdata_r <= '0;
		end else begin
			mode_r <= mode_nxt;
			com_r <= com_nxt;
			state_r <= state_nxt;
			flag_r <= flag_nxt;
			block_r <= block_nxt;
			match_r <= real_match;
			count_wr_r <= wr_count;
			count_wdata_r <= wr_count ? PWDATA_IN[CNT_W-1:0] : count_wdata_r;
			rdata_r <= rd_en ? rdata_nxt : rdata_r;
		end
	end

	// ************************************************************
	// outputs
	// ************************************************************
	assign PREADY_OUT = 1'b1;
	assign PSLVERR_OUT = PSEL_IN && PENABLE_IN && !hit_any;
	assign PRDATA_OUT = rd_en ? rdata_nxt : rdata_r;
	assign COUNT_WR_OUT = count_wr_r;
	assign COUNT_WDATA_OUT = count_wdata_r;
	assign MATCH_OUT = match_r;
	assign FLAG_OUT = flag_r;
	assign PIN_OUT = com_off ? PORT_IN : state_r;

	// ************************************************************
	// checks
	// ************************************************************
	a_match_sets_flag: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
		TICK_IN && equal && !block_r |=> flag_r && MATCH_OUT)
		else $error("match did not set the flag");
	a_force_no_flag: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
		forced && !TICK_IN && !flag_r |=> !flag_r && !MATCH_OUT)
		else $error("forced match set the flag");
	a_write_blocks: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
		wr_count ##1 (TICK_IN && !wr_count) |=> !MATCH_OUT && $stable(flag_r))
		else $error("match not blocked after counter write");
	a_block_held: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
		wr_count ##1 !TICK_IN [*3] |-> block_r)
		else $error("block released before a timer tick");
	a_force_toggle: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
		forced && com_r == COM_TOGGLE && !TICK_IN |=> state_r != $past(state_r))
		else $error("forced toggle did not toggle");
	a_force_pwm_ignored: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
		wr_force && !non_pwm && !TICK_IN |=> $stable(state_r))
		else $error("force acted in a pwm mode");
	a_mode_keeps_state: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
		wr_ctrl && !TICK_IN && !forced |=> state_r == $past(state_r))
		else $error("mode change altered the output state");
	a_pin_source: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
		com_off |-> PIN_OUT == PORT_IN)
		else $error("pin not driven by port logic when mode field is zero");
	a_com_immediate: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
		wr_ctrl && PWDATA_IN[CTRL_COM_LSB +: COM_W] != COM_OFF |=> PIN_OUT == state_r)
		else $error("mode field write did not take effect at once");
	a_clear_match: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
		real_match && non_pwm && com_r == COM_CLEAR |=> !state_r)
		else $error("clear on match did not clear");
	a_reset_state: assert property (@(posedge CLOCK_IN)
		$rose(RST_N_IN) |-> !state_r)
		else $error("output state not zero after reset");

endmodule
